// *** timer_capture_pkg.sv ***
// Constants, register map and field layout of the external capture control block
package timer_capture_pkg;

	// ****************************************************************
	// Widths
	// ****************************************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W  = 24;
	localparam int CTL_W  = 9;

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [ADDR_W-1:0] OFS_COUNTER  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_CAPTURE  = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_EXT_CTL  = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_EXT_STS  = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_CNT_CTL  = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_EVT_STS  = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 8'h24;

	// ****************************************************************
	// External capture control fields
	// ****************************************************************
	localparam int CTL_MODE_SEL_BIT = 8;
	localparam int CTL_CNT_DB_BIT   = 7;
	localparam int CTL_CAP_DB_BIT   = 6;
	localparam int CTL_CAP_IEN_BIT  = 5;
	localparam int CTL_CAP_RST_BIT  = 4;
	localparam int CTL_CAP_EN_BIT   = 3;
	localparam int CTL_EDGE_LSB     = 1;
	localparam int CTL_PHASE_BIT    = 0;
	localparam logic [CTL_W-1:0] CTL_RESET = 9'h000;

	// ****************************************************************
	// Status, counter control and event fields
	// ****************************************************************
	localparam int STS_CAPTURE_INTERRUPT_FLAG_BIT = 0;
	localparam int STS_CAPTURE_FLAG_BIT  = 1;
	localparam int RUN_BIT       = 0;
	localparam int EVT_MODE_BIT  = 1;
	localparam int SRC_32K_BIT   = 2;
	localparam logic [2:0] CNT_CTL_RESET = 3'h0;
	localparam int EVT_CAP_BIT   = 0;
	localparam int EVT_OVF_BIT   = 1;
	localparam logic [1:0] EVT_RESET = 2'h0;

	typedef enum logic [1:0] {
		EDGE_FALL = 2'h0,
		EDGE_RISE = 2'h1,
		EDGE_BOTH = 2'h2,
		EDGE_NONE = 2'h3
	} edge_sel_t;

	// ****************************************************************
	// Timing and bus answers
	// ****************************************************************
	localparam int CLK_PERIOD_NS   = 4;
	localparam int DEBOUNCE_NS     = 12;
	localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** level_debounce.sv ***
// Stability filter for one synchronised input level, with bypass
`timescale 1ns/10ps
module level_debounce #(
	parameter int STABLE_CYCLES = timer_capture_pkg::DEBOUNCE_CYCLES
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic enable,
	input  wire logic level_in,
	output logic      level_out
);

	logic [3:0] run_ff;
	logic       stable_ff;

	// A new level is accepted only after it held for the whole window
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_ff    <= 4'h0;
			stable_ff <= 1'b0;
		end else if (!enable || level_in == stable_ff) begin
			run_ff    <= 4'h0;
			stable_ff <= enable ? stable_ff : level_in;
		end else if (run_ff == 4'(STABLE_CYCLES - 1)) begin
			run_ff    <= 4'h0;
			stable_ff <= level_in;
		end else begin
			run_ff    <= run_ff + 4'h1;
		end
	end

	assign level_out = enable ? stable_ff : level_in;

endmodule

// *** timer_external_capture_control.sv ***
// External capture and event counting control of a 24-bit timer, AXI4-Lite slave
//
// Notes on behaviour
// - bit 8 picks free/reset or trigger capture
// - bit 7 debounces the event count input
// - bit 6 debounces the capture input
// - interrupt while enable and interrupt flag high
// - reset select clear: capture copies counter only
// - reset select set, free/reset mode: capture, then counter zero
// - capture enable bit gates all captures
// - edge field: falling, rising, either, reserved
// - phase bit picks counted event edge
// - capture flag bit 1, write one clears
// - interrupt flag bit 0 needs enable, W1C
// - matching edge sets flag, loads captured value
// - capture flag sets regardless of interrupt enable
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps
module timer_external_capture_control (
	input  wire logic                                 clk,
	input  wire logic                                 rst_n,
	input  wire logic [timer_capture_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                                 awvalid,
	output logic                                      awready,
	input  wire logic [timer_capture_pkg::DATA_W-1:0] wdata,
	input  wire logic [3:0]                           wstrb,
	input  wire logic                                 wvalid,
	output logic                                      wready,
	output logic [1:0]                                bresp,
	output logic                                      bvalid,
	input  wire logic                                 bready,
	input  wire logic [timer_capture_pkg::ADDR_W-1:0] araddr,
	input  wire logic                                 arvalid,
	output logic                                      arready,
	output logic [timer_capture_pkg::DATA_W-1:0]      rdata,
	output logic [1:0]                                rresp,
	output logic                                      rvalid,
	input  wire logic                                 rready,
	input  wire logic                                 capture_input_pin,
	input  wire logic                                 event_count_pin,
	input  wire logic                                 clk_32k_in,
	output logic                                      irq
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [timer_capture_pkg::ADDR_W-1:0] awaddr_ff;
	logic [timer_capture_pkg::DATA_W-1:0] wdata_ff;
	logic [3:0]                           wstrb_ff;
	logic                                 aw_full_ff;
	logic                                 w_full_ff;
	logic                                 awready_ff;
	logic                                 wready_ff;
	logic                                 bvalid_ff;
	logic [1:0]                           bresp_ff;
	logic                                 arready_ff;
	logic                                 rvalid_ff;
	logic [1:0]                           rresp_ff;
	logic [timer_capture_pkg::DATA_W-1:0] rdata_ff;
	logic                                 irq_ff;

	logic [timer_capture_pkg::CTL_W-1:0]  ctl_ff;
	logic [2:0]                           cnt_ctl_ff;
	logic                                 capture_flag_ff;
	logic                                 capture_interrupt_flag_ff;
	logic [1:0]                           evt_sts_ff;
	logic [1:0]                           evt_mask_ff;
	logic [timer_capture_pkg::CNT_W-1:0]  counter_value_ff;
	logic [timer_capture_pkg::CNT_W-1:0]  captured_count_value_ff;

	logic [2:0]                           meta_ff;
	logic [2:0]                           sync_ff;
	logic                                 cap_prev_ff;
	logic                                 evt_prev_ff;
	logic                                 primed_ff;

	logic aw_take;
	logic w_take;
	logic do_write;
	logic ar_take;
	logic nxt_aw_full;
	logic nxt_w_full;
	logic nxt_bvalid;
	logic nxt_rvalid;
	logic wr_ok;
	logic rd_ok;
	logic [timer_capture_pkg::DATA_W-1:0] rd_word;

	logic      capture_enable;
	logic      capture_reset_select;
	logic      capture_mode_select;
	logic      capture_interrupt_enable;
	logic      count_edge_phase;
	timer_capture_pkg::edge_sel_t capture_edge_select;
	logic      cap_raw;
	logic      cap_lvl;
	logic      evt_lvl;
	logic      cap_rise;
	logic      cap_fall;
	logic      evt_rise;
	logic      evt_fall;
	logic      edge_match;
	logic      cap_hit;
	logic      cnt_tick;
	logic      cnt_clear;
	logic      cnt_wrap;
	logic      wr_sts;
	logic      rd_evt;

	assign capture_mode_select      = ctl_ff[timer_capture_pkg::CTL_MODE_SEL_BIT];
	assign capture_interrupt_enable = ctl_ff[timer_capture_pkg::CTL_CAP_IEN_BIT];
	assign capture_reset_select     = ctl_ff[timer_capture_pkg::CTL_CAP_RST_BIT];
	assign capture_enable           = ctl_ff[timer_capture_pkg::CTL_CAP_EN_BIT];
	assign count_edge_phase         = ctl_ff[timer_capture_pkg::CTL_PHASE_BIT];
	assign capture_edge_select      =
		timer_capture_pkg::edge_sel_t'(ctl_ff[timer_capture_pkg::CTL_EDGE_LSB +: 2]);

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= 3'h0;
			sync_ff <= 3'h0;
		end else begin
			meta_ff <= {clk_32k_in, event_count_pin, capture_input_pin};
			sync_ff <= meta_ff;
		end
	end

	// Capture may watch the 32 kHz clock instead of the pin
	assign cap_raw = cnt_ctl_ff[timer_capture_pkg::SRC_32K_BIT] ? sync_ff[2] : sync_ff[0];

	level_debounce u_cap_debounce (
		.clk       (clk),
		.rst_n     (rst_n),
		.enable    (ctl_ff[timer_capture_pkg::CTL_CAP_DB_BIT]),
		.level_in  (cap_raw),
		.level_out (cap_lvl)
	);

	level_debounce u_evt_debounce (
		.clk       (clk),
		.rst_n     (rst_n),
		.enable    (ctl_ff[timer_capture_pkg::CTL_CNT_DB_BIT]),
		.level_in  (sync_ff[1]),
		.level_out (evt_lvl)
	);

	// ****************************************************************
	// Edge detection
	// ****************************************************************
	// First cycle after reset only loads history; a pin high at reset still shows as a rise once the synchronisers pass it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_prev_ff <= 1'b0;
			evt_prev_ff <= 1'b0;
			primed_ff   <= 1'b0;
		end else begin
			cap_prev_ff <= cap_lvl;
			evt_prev_ff <= evt_lvl;
			primed_ff   <= 1'b1;
		end
	end

	assign cap_rise = primed_ff && cap_lvl && !cap_prev_ff;
	assign cap_fall = primed_ff && !cap_lvl && cap_prev_ff;
	assign evt_rise = primed_ff && evt_lvl && !evt_prev_ff;
	assign evt_fall = primed_ff && !evt_lvl && evt_prev_ff;

	always_comb begin
		case (capture_edge_select)
			timer_capture_pkg::EDGE_FALL: edge_match = cap_fall;
			timer_capture_pkg::EDGE_RISE: edge_match = cap_rise;
			timer_capture_pkg::EDGE_BOTH: edge_match = cap_rise || cap_fall;
			default:                      edge_match = 1'b0;
		endcase
	end

	assign cap_hit = capture_enable && edge_match;

	// ****************************************************************
	// Counter and capture
	// ****************************************************************
	assign cnt_tick = cnt_ctl_ff[timer_capture_pkg::RUN_BIT] &&
		(cnt_ctl_ff[timer_capture_pkg::EVT_MODE_BIT] ?
		(count_edge_phase ? evt_rise : evt_fall) : 1'b1);
	// Counter reset on capture only in free/reset mode
	assign cnt_clear = cap_hit && capture_reset_select && !capture_mode_select;
	assign cnt_wrap  = cnt_tick && !cnt_clear && (&counter_value_ff);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			counter_value_ff <= 24'h000000;
		end else if (cnt_clear) begin
			counter_value_ff <= 24'h000000;
		end else if (cnt_tick) begin
			counter_value_ff <= counter_value_ff + 24'h000001;
		end
	end

	// Old count is taken in the same edge as the clear; a tick in that same cycle is dropped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			captured_count_value_ff <= 24'h000000;
		end else if (cap_hit) begin
			captured_count_value_ff <= counter_value_ff;
		end
	end

	// ****************************************************************
	// Capture status flags
	// ****************************************************************
	assign wr_sts = do_write && awaddr_ff == timer_capture_pkg::OFS_EXT_STS && wstrb_ff[0];

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			capture_flag_ff <= 1'b0;
		end else if (cap_hit) begin
			capture_flag_ff <= 1'b1;
		end else if (wr_sts && wdata_ff[timer_capture_pkg::STS_CAPTURE_FLAG_BIT]) begin
			capture_flag_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			capture_interrupt_flag_ff <= 1'b0;
		end else if (cap_hit && capture_interrupt_enable) begin
			capture_interrupt_flag_ff <= 1'b1;
		end else if (wr_sts && wdata_ff[timer_capture_pkg::STS_CAPTURE_INTERRUPT_FLAG_BIT]) begin
			capture_interrupt_flag_ff <= 1'b0;
		end
	end

	// Sticky events, cleared by reading them; a new event wins the read
	// Same word decode as the read mux, so any read that returns the events clears them
	assign rd_evt = ar_take && {araddr[7:2], 2'h0} == timer_capture_pkg::OFS_EVT_STS;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			evt_sts_ff <= timer_capture_pkg::EVT_RESET;
		end else begin
			evt_sts_ff <= (rd_evt ? 2'h0 : evt_sts_ff) | {cnt_wrap, cap_hit};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= (capture_interrupt_enable && capture_interrupt_flag_ff) ||
				(|(evt_sts_ff & evt_mask_ff));
		end
	end

	// ****************************************************************
	// Control registers
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_ff      <= timer_capture_pkg::CTL_RESET;
			cnt_ctl_ff  <= timer_capture_pkg::CNT_CTL_RESET;
			evt_mask_ff <= timer_capture_pkg::EVT_RESET;
		end else if (do_write) begin
			if (awaddr_ff == timer_capture_pkg::OFS_EXT_CTL) begin
				if (wstrb_ff[0]) begin
					ctl_ff[7:0] <= wdata_ff[7:0];
				end
				if (wstrb_ff[1]) begin
					ctl_ff[8] <= wdata_ff[8];
				end
			end
			if (awaddr_ff == timer_capture_pkg::OFS_CNT_CTL && wstrb_ff[0]) begin
				cnt_ctl_ff <= wdata_ff[2:0];
			end
			if (awaddr_ff == timer_capture_pkg::OFS_EVT_MASK && wstrb_ff[0]) begin
				evt_mask_ff <= wdata_ff[1:0];
			end
		end
	end

	// ****************************************************************
	// AXI4-Lite write channels
	// ****************************************************************
	assign aw_take  = awvalid && awready_ff;
	assign w_take   = wvalid && wready_ff;
	assign do_write = aw_full_ff && w_full_ff && !bvalid_ff;

	assign nxt_aw_full = (aw_full_ff || aw_take) && !do_write;
	assign nxt_w_full  = (w_full_ff || w_take) && !do_write;
	assign nxt_bvalid  = do_write || (bvalid_ff && !bready);

	always_comb begin
		case (awaddr_ff)
			timer_capture_pkg::OFS_COUNTER,
			timer_capture_pkg::OFS_CAPTURE,
			timer_capture_pkg::OFS_EXT_CTL,
			timer_capture_pkg::OFS_EXT_STS,
			timer_capture_pkg::OFS_CNT_CTL,
			timer_capture_pkg::OFS_EVT_STS,
			timer_capture_pkg::OFS_EVT_MASK: wr_ok = 1'b1;
			default:                         wr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			awaddr_ff  <= 8'h00;
			wdata_ff   <= 32'h00000000;
			wstrb_ff   <= 4'h0;
			aw_full_ff <= 1'b0;
			w_full_ff  <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= timer_capture_pkg::RESP_OKAY;
		end else begin
			if (aw_take) begin
				awaddr_ff <= {awaddr[7:2], 2'h0};
			end
			if (w_take) begin
				wdata_ff <= wdata;
				wstrb_ff <= wstrb;
			end
			if (do_write) begin
				bresp_ff <= wr_ok ? timer_capture_pkg::RESP_OKAY : timer_capture_pkg::RESP_SLVERR;
			end
			aw_full_ff <= nxt_aw_full;
			w_full_ff  <= nxt_w_full;
			bvalid_ff  <= nxt_bvalid;
			awready_ff <= !nxt_aw_full && !nxt_bvalid;
			wready_ff  <= !nxt_w_full && !nxt_bvalid;
		end
	end

	// ****************************************************************
	// AXI4-Lite read channels
	// ****************************************************************
	assign ar_take    = arvalid && arready_ff;
	assign nxt_rvalid = ar_take || (rvalid_ff && !rready);

	always_comb begin
		rd_word = 32'h00000000;
		rd_ok   = 1'b1;
		case ({araddr[7:2], 2'h0})
			timer_capture_pkg::OFS_COUNTER:  rd_word[23:0] = counter_value_ff;
			timer_capture_pkg::OFS_CAPTURE:  rd_word[23:0] = captured_count_value_ff;
			timer_capture_pkg::OFS_EXT_CTL:  rd_word[8:0] = ctl_ff;
			timer_capture_pkg::OFS_EXT_STS:  rd_word[1:0] = {capture_flag_ff, capture_interrupt_flag_ff};
			timer_capture_pkg::OFS_CNT_CTL:  rd_word[2:0] = cnt_ctl_ff;
			timer_capture_pkg::OFS_EVT_STS:  rd_word[1:0] = evt_sts_ff;
			timer_capture_pkg::OFS_EVT_MASK: rd_word[1:0] = evt_mask_ff;
			default:                         rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h00000000;
			rresp_ff   <= timer_capture_pkg::RESP_OKAY;
		end else begin
			if (ar_take) begin
				rdata_ff <= rd_word;
				rresp_ff <= rd_ok ? timer_capture_pkg::RESP_OKAY : timer_capture_pkg::RESP_SLVERR;
			end
			rvalid_ff  <= nxt_rvalid;
			arready_ff <= !nxt_rvalid;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign awready = awready_ff;
	assign wready  = wready_ff;
	assign bvalid  = bvalid_ff;
	assign bresp   = bresp_ff;
	assign arready = arready_ff;
	assign rvalid  = rvalid_ff;
	assign rresp   = rresp_ff;
	assign rdata   = rdata_ff;
	assign irq     = irq_ff;

endmodule

// *** timer_capture_monitor.sv ***
// Bus and register read-back checks on the capture block ports
`timescale 1ns/10ps
module timer_capture_monitor (
	input wire logic                                 clk,
	input wire logic                                 rst_n,
	input wire logic                                 awready,
	input wire logic                                 awvalid,
	input wire logic                                 wready,
	input wire logic                                 wvalid,
	input wire logic [1:0]                           bresp,
	input wire logic                                 bvalid,
	input wire logic                                 bready,
	input wire logic [timer_capture_pkg::ADDR_W-1:0] araddr,
	input wire logic                                 arvalid,
	input wire logic                                 arready,
	input wire logic [timer_capture_pkg::DATA_W-1:0] rdata,
	input wire logic [1:0]                           rresp,
	input wire logic                                 rvalid,
	input wire logic                                 rready
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ****************************************************************
	// Address of the read in flight
	// ****************************************************************
	logic [7:0] rd_addr_ff;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_addr_ff <= 8'h00;
		end else if (arvalid && arready) begin
			rd_addr_ff <= {araddr[7:2], 2'h0};
		end
	end

	sequence s_wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_rd_taken;
		arvalid && arready;
	endsequence

	// ****************************************************************
	// Properties
	// ****************************************************************
	a_bvalid_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("bvalid or bresp dropped before bready");
	a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer changed before rready");
	a_read_answer: assert property (s_rd_taken |=> rvalid)
		else $error("read answer late");
	a_write_answer: assert property (s_wr_taken |=> !bvalid ##1 bvalid)
		else $error("write answer not two cycles after acceptance");
	a_write_refused: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while response pending");
	a_read_refused: assert property (rvalid |-> !arready)
		else $error("read accepted while read data pending");
	a_slot_reopens: assert property (bvalid && bready |=> awready && wready && !bvalid)
		else $error("write slot not free after response");
	a_read_release: assert property (rvalid && rready |=> !rvalid)
		else $error("read data kept after rready");
	a_status_reserved: assert property (rvalid && rd_addr_ff == timer_capture_pkg::OFS_EXT_STS |->
		rdata[31:2] == 30'h0)
		else $error("status reserved bits not zero");
	a_control_reserved: assert property (rvalid && rd_addr_ff == timer_capture_pkg::OFS_EXT_CTL |->
		rdata[31:9] == 23'h0)
		else $error("control reserved bits not zero");
	a_error_data_zero: assert property (rvalid && rresp == timer_capture_pkg::RESP_SLVERR |->
		rdata == 32'h0)
		else $error("error read returned data");
endmodule

// *** ext_pin_model.sv ***
// Behavioural driver of the capture, event and 32 kHz inputs
`timescale 1ns/10ps
module ext_pin_model (
	input wire logic clk,
	output logic     cap_pin,
	output logic     evt_pin,
	output logic     k32_pin
);
	initial begin
		cap_pin = 1'b0;
		evt_pin = 1'b0;
		k32_pin = 1'b0;
	end
	// Pin 0 capture, 1 event, 2 slow clock; level held for hold cycles
	task automatic set_pin(input int sel, input logic v, input int hold);
		@(posedge clk);
		case (sel)
			0: cap_pin <= v;
			1: evt_pin <= v;
			default: k32_pin <= v;
		endcase
		repeat (hold - 1) @(posedge clk);
	endtask
	// Long low tail lets sync, filter and flag logic settle
	task automatic pulse(input int sel, input int hi);
		set_pin(sel, 1'b1, hi);
		set_pin(sel, 1'b0, 12);
	endtask
endmodule

// *** timer_external_capture_control_bench.sv ***
// Self-checking bench of the external capture control block
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin errors++; \
	$display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module timer_external_capture_control_bench;
	localparam logic [7:0] CNT = timer_capture_pkg::OFS_COUNTER;
	localparam logic [7:0] CAP = timer_capture_pkg::OFS_CAPTURE;
	localparam logic [7:0] CTL = timer_capture_pkg::OFS_EXT_CTL;
	localparam logic [7:0] STS = timer_capture_pkg::OFS_EXT_STS;
	localparam logic [7:0] CCT = timer_capture_pkg::OFS_CNT_CTL;
	localparam logic [7:0] EVS = timer_capture_pkg::OFS_EVT_STS;
	localparam logic [7:0] EVM = timer_capture_pkg::OFS_EVT_MASK;
	logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic        cap_pin, evt_pin, k32_pin;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	int          errors, n_tests;

	always #2 clk = ~clk;

	timer_external_capture_control uut (.clk(clk), .rst_n(rst_n), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.capture_input_pin(cap_pin), .event_count_pin(evt_pin),
		.clk_32k_in(k32_pin), .irq(irq));
	ext_pin_model pins (.clk(clk), .cap_pin(cap_pin), .evt_pin(evt_pin), .k32_pin(k32_pin));

	// ****************************************************************
	// Bus tasks
	// ****************************************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			t++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && t < 50);
		bready <= 1'b0;
		resp = bresp;
		if (t >= 50) errors++;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			t++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && t < 50);
		rready <= 1'b0;
		d = rdata;
		resp = rresp;
		if (t >= 50) errors++;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] ex, input string nm);
		logic [31:0] d;
		rd(a, d);
		`CHK(nm, ex, d)
	endtask
	task automatic print_verdict();
		$display("tests %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		{clk, rst_n, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hF;
		errors = 0;
		n_tests = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rc(CTL, 32'h0, "ctl reset");
		`CHK("rresp ok", timer_capture_pkg::RESP_OKAY, resp)
		rc(STS, 32'h0, "sts reset");
		rc(8'h40, 32'h0, "unmapped rd");
		`CHK("rresp", timer_capture_pkg::RESP_SLVERR, resp)
		wr(8'h40, 32'hFFFFFFFF);
		`CHK("bresp", timer_capture_pkg::RESP_SLVERR, resp)
		wr(CTL, 32'hFFFFFFFF);
		`CHK("bresp ok", timer_capture_pkg::RESP_OKAY, resp)
		rc(CTL, 32'h1FF, "ctl rsvd");
		wr(STS, 32'hFFFFFFFF);
		rc(STS, 32'h0, "sts rsvd");
		wr(CTL, 32'h1);
		wr(CCT, 32'h3);
		repeat (3) pins.pulse(1, 6);
		rc(CNT, 32'h3, "rise count");
		wr(CTL, 32'h0);
		repeat (3) pins.pulse(1, 6);
		rc(CNT, 32'h6, "fall count");
		wr(CTL, 32'h80);
		pins.pulse(1, 2);
		rc(CNT, 32'h6, "evt filtered");
		wr(CTL, 32'h0);
		pins.pulse(1, 2);
		rc(CNT, 32'h7, "evt raw");
		wr(CTL, 32'h4);
		pins.pulse(0, 6);
		rc(STS, 32'h0, "cap off");
		for (int e = 0; e < 4; e++) begin
			wr(CTL, 32'h8 | (e << 1));
			pins.set_pin(0, 1'b1, 12);
			rc(STS, {30'h0, (e == 1 || e == 2), 1'b0}, "rise edge");
			wr(STS, 32'h3);
			pins.set_pin(0, 1'b0, 12);
			rc(STS, {30'h0, (e == 0 || e == 2), 1'b0}, "fall edge");
			wr(STS, 32'h3);
		end
		rc(CAP, 32'h7, "cap value");
		wr(CTL, 32'h1A);
		pins.pulse(0, 6);
		rc(CAP, 32'h7, "cap rst");
		rc(CNT, 32'h0, "cnt zero");
		repeat (2) pins.pulse(1, 6);
		wr(CTL, 32'hA);
		pins.pulse(0, 6);
		rc(CAP, 32'h2, "cap keep");
		rc(CNT, 32'h2, "cnt keep");
		wr(CTL, 32'h11A);
		pins.pulse(0, 6);
		rc(CNT, 32'h2, "trig mode");
		wr(STS, 32'h3);
		wr(CTL, 32'h4A);
		pins.pulse(0, 2);
		rc(STS, 32'h0, "cap filtered");
		wr(CTL, 32'hA);
		pins.pulse(0, 2);
		rc(STS, 32'h2, "cap raw");
		wr(STS, 32'h3);
		wr(CTL, 32'h2A);
		pins.pulse(0, 6);
		rc(STS, 32'h3, "flags");
		`CHK("irq set", 1'b1, irq)
		wr(STS, 32'h0);
		rc(STS, 32'h3, "w0 keeps");
		wr(STS, 32'h2);
		rc(STS, 32'h1, "capture_flag clr");
		wr(CTL, 32'hA);
		repeat (3) @(posedge clk);
		`CHK("irq off", 1'b0, irq)
		wr(CTL, 32'h2A);
		repeat (3) @(posedge clk);
		`CHK("irq on", 1'b1, irq)
		wr(STS, 32'h1);
		repeat (3) @(posedge clk);
		`CHK("irq clr", 1'b0, irq)
		rc(EVS, 32'h1, "evt sts");
		rc(EVS, 32'h0, "evt rd clr");
		wr(EVM, 32'h1);
		wr(CTL, 32'hA);
		pins.pulse(0, 6);
		`CHK("mask irq", 1'b1, irq)
		rc(EVS, 32'h1, "evt sts2");
		repeat (3) @(posedge clk);
		`CHK("mask irq clr", 1'b0, irq)
		wr(CCT, 32'h7);
		wr(STS, 32'h3);
		pins.pulse(2, 6);
		rc(STS, 32'h2, "slow clk cap");
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		print_verdict();
	end
endmodule

bind timer_external_capture_control timer_capture_monitor mon (.clk(clk), .rst_n(rst_n),
	.awready(awready), .awvalid(awvalid), .wready(wready), .wvalid(wvalid),
	.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
	.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
	.rvalid(rvalid), .rready(rready));
